// ### ssr_pkg.sv
package ssr_pkg;
   // Frame geometry
   localparam int         DATA_BITS      = 12;
   localparam int         FRAME_BITS     = 16;
   localparam int         CNT_W          = 5;
   localparam logic [4:0] FRAME_CLOCKS   = 5'h10;
   localparam logic [4:0] HDR_READY_CNT  = 5'h03;
   localparam logic [4:0] CNT_MAX        = 5'h1F;
   localparam logic [4:0] CNT_ONE        = 5'h01;
   localparam int         FB_HI          = 14;
   localparam int         FB_LO          = 3;

   // Register addresses
   localparam logic [1:0] ADDR_CONTROL   = 2'h0;
   localparam logic [1:0] ADDR_IRQ       = 2'h1;
   localparam logic [1:0] ADDR_SETUP     = 2'h2;
   localparam logic [1:0] ADDR_XCVR      = 2'h3;

   // Operating select codes
   localparam logic [2:0] OM_NORMAL      = 3'h1;
   localparam logic [2:0] OM_STANDBY     = 3'h2;
   localparam logic [2:0] OM_SLEEP       = 3'h4;
   localparam logic [2:0] OM_INIT_NORMAL = 3'h5;
   localparam logic [2:0] OM_INIT_FLASH  = 3'h6;

   // Legal watch period codes
   localparam logic [5:0] WP_C0 = 6'h09;
   localparam logic [5:0] WP_C1 = 6'h0C;
   localparam logic [5:0] WP_C2 = 6'h12;
   localparam logic [5:0] WP_C3 = 6'h14;
   localparam logic [5:0] WP_C4 = 6'h1B;
   localparam logic [5:0] WP_C5 = 6'h24;
   localparam logic [5:0] WP_C6 = 6'h2D;
   localparam logic [5:0] WP_C7 = 6'h33;
   localparam logic [5:0] WP_C8 = 6'h35;
   localparam logic [5:0] WP_C9 = 6'h36;

   // Field positions and reset values
   localparam int          SDM_POS        = 0;
   localparam int          OPT_SDM_POS    = 0;
   localparam int          MASK_FAIL_POS  = 0;
   localparam int          ID_FLAG_POS    = 11;
   localparam logic [11:0] WORD_ZERO      = 12'h000;
   localparam logic [15:0] FRAME_ZERO     = 16'h0000;

   typedef struct packed {
      logic [1:0]  addr;
      logic        readback_choice;
      logic        no_write_flag;
      logic [11:0] data;
   } ssr_frame_t;

   typedef struct packed {
      logic [5:0] watch_period_code;
      logic [2:0] operating_select;
      logic       watchdog_off_bit;
      logic [1:0] spare;
   } ssr_ctrl_word_t;

   typedef enum logic [2:0] {
      MD_STARTUP, MD_RESTART, MD_NORMAL, MD_STANDBY, MD_FLASH, MD_SLEEP, MD_FAILSAFE
   } ssr_mode_t;
endpackage

// ### ssr_spi_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Select low; output undriven while select high
// - Frames only taken while system reset high
// - Not 16 clocks: ignore, interrupt or reset
// - Restart: only initializing-normal; start-up also init-flash; else reset
// - Init-flash only in start-up after sequence
// - Watchdog-off bit in control word: reset
// - Illegal watch period code: reset
// - Illegal code in normal/standby: reset
// - Read-only address zero ignores data bits
// - Frame is 4 header, 12 data bits
// - Header: address 15:14, readback, no-write
// - Every frame returns selected feedback word
// - No-write flag: return only, no update
// - Period and mode update in one access
// - Once-only options writable once at power-up
// - Software development bit readable and clearable
// - Scratch zero holds identity, scratch one cleared
// - Scratch writable only start-up, restart, flash
// - Address 00: control word, status/fault readback
// - Address 01: mask or options, mask/flags readback
// - Addresses 10/11: setup/transceiver or scratch words
// - Sample on falling, shift on rising edge
module ssr_spi_regs
   import ssr_pkg::*;
#(
   parameter logic [10:0] ID_CODE = 11'h2A5  // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           reset_n,
   // Serial pins
   input  wire logic           frame_select_n,
   input  wire logic           serial_clk,
   input  wire logic           serial_in,
   output logic                serial_out,
   output logic                serial_out_en,
   input  wire logic           system_reset_n,
   // Device state
   input  wire ssr_mode_t      cur_mode,
   input  wire logic           power_on_start,
   input  wire logic           flash_seq_seen,
   input  wire logic [11:0]    system_condition_readback,
   input  wire logic [11:0]    fault_report_readback,
   input  wire logic [11:0]    irq_flags,
   // Register outputs
   output ssr_ctrl_word_t      operation_control_word,
   output logic                ctrl_update,
   output logic                reset_request,
   output logic                spi_fail_irq,
   output logic                irq_flags_read,
   output logic [11:0]         irq_mask,
   output logic [11:0]         once_only_options,
   output logic [11:0]         system_setup,
   output logic [11:0]         transceiver_control,
   output logic [11:0]         scratch_word_zero,
   output logic [11:0]         scratch_word_one
);

   // Pin synchronisers
   logic [3:0]     pin_m_q;
   logic           sel_s_q;
   logic           sck_s_q;
   logic           sdi_s_q;
   logic           rst_s_q;
   logic           sel_p_q;
   logic           sck_p_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_m_q <= 4'h8;
         sel_s_q <= 1'b1;
         sck_s_q <= 1'b0;
         sdi_s_q <= 1'b0;
         rst_s_q <= 1'b0;
         sel_p_q <= 1'b1;
         sck_p_q <= 1'b0;
      end else begin
         pin_m_q <= {frame_select_n, serial_clk, serial_in, system_reset_n};
         sel_s_q <= pin_m_q[3];
         sck_s_q <= pin_m_q[2];
         sdi_s_q <= pin_m_q[1];
         rst_s_q <= pin_m_q[0];
         sel_p_q <= sel_s_q;
         sck_p_q <= sck_s_q;
      end
   end

   logic frame_start;
   logic frame_end;
   logic sck_fall;
   logic sck_rise;

   assign frame_start = sel_p_q && !sel_s_q;
   assign frame_end   = !sel_p_q && sel_s_q;
   assign sck_fall    = !sel_s_q && sck_p_q && !sck_s_q;
   assign sck_rise    = !sel_s_q && !sck_p_q && sck_s_q;

   // Receive shifter and clock count
   logic [15:0]    rx_q;
   logic [4:0]     cnt_q;
   logic           live_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_q  <= FRAME_ZERO;
         cnt_q <= 5'h00;
      end else if (frame_start) begin
         rx_q  <= FRAME_ZERO;
         cnt_q <= 5'h00;
      end else if (sck_fall) begin
         rx_q  <= {rx_q[14:0], sdi_s_q};
         if (cnt_q != CNT_MAX)
            cnt_q <= cnt_q + CNT_ONE;
      end
   end

   // Frame discarded if system reset seen low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         live_q <= 1'b0;
      end else if (frame_start) begin
         live_q <= rst_s_q;
      end else if (!rst_s_q) begin
         live_q <= 1'b0;
      end
   end

   ssr_frame_t     frame;
   ssr_ctrl_word_t cw;
   logic           count_ok;
   logic           frame_ok;
   logic           frame_bad;
   logic           do_write;

   assign frame     = ssr_frame_t'(rx_q);
   assign cw        = ssr_ctrl_word_t'(frame.data);
   assign count_ok  = (cnt_q == FRAME_CLOCKS);
   assign frame_ok  = frame_end && live_q && rst_s_q && count_ok;
   assign frame_bad = frame_end && live_q && rst_s_q && !count_ok;
   assign do_write  = frame_ok && !frame.no_write_flag;

   // Mode groups
   logic in_startup;
   logic in_restart;
   logic in_run;
   logic in_prog;

   assign in_startup = (cur_mode == MD_STARTUP);
   assign in_restart = (cur_mode == MD_RESTART);
   assign in_run     = (cur_mode == MD_NORMAL) || (cur_mode == MD_STANDBY);
   assign in_prog    = in_startup || in_restart || (cur_mode == MD_FLASH);

   // Control word legality check
   logic period_ok;
   logic om_run_ok;
   logic cw_bad;

   always_comb begin
      case (cw.watch_period_code)
         WP_C0, WP_C1, WP_C2, WP_C3, WP_C4,
         WP_C5, WP_C6, WP_C7, WP_C8, WP_C9: period_ok = 1'b1;
         default:                           period_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (cw.operating_select)
         OM_NORMAL, OM_STANDBY, OM_SLEEP: om_run_ok = 1'b1;
         default:                         om_run_ok = 1'b0;
      endcase
   end

   always_comb begin
      cw_bad = !period_ok || cw.watchdog_off_bit;
      case (cur_mode)
         MD_STARTUP: begin
            if (cw.operating_select == OM_INIT_FLASH)
               cw_bad = cw_bad || !flash_seq_seen;
            else if (cw.operating_select != OM_INIT_NORMAL)
               cw_bad = 1'b1;
         end
         MD_RESTART: begin
            if (cw.operating_select != OM_INIT_NORMAL)
               cw_bad = 1'b1;
         end
         default: begin
            if (!om_run_ok)
               cw_bad = 1'b1;
         end
      endcase
   end

   logic wr_ctrl;
   logic wr_mask;
   logic wr_opts;
   logic wr_setup;
   logic wr_xcvr;
   logic wr_scr0;
   logic wr_scr1;
   logic once_closed_q;

   assign wr_ctrl  = do_write && (frame.addr == ADDR_CONTROL);
   assign wr_mask  = do_write && (frame.addr == ADDR_IRQ) && in_run;
   assign wr_opts  = do_write && (frame.addr == ADDR_IRQ) && in_startup
                     && power_on_start && !once_closed_q;
   assign wr_setup = do_write && (frame.addr == ADDR_SETUP) && in_run;
   assign wr_xcvr  = do_write && (frame.addr == ADDR_XCVR) && in_run;
   assign wr_scr0  = do_write && (frame.addr == ADDR_SETUP) && in_prog;
   assign wr_scr1  = do_write && (frame.addr == ADDR_XCVR) && in_prog;

   // Event pulses
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reset_request  <= 1'b0;
         spi_fail_irq   <= 1'b0;
         irq_flags_read <= 1'b0;
         ctrl_update    <= 1'b0;
      end else begin
         reset_request  <= (frame_bad && (in_startup || in_restart))
                           || (wr_ctrl && cw_bad);
         spi_fail_irq   <= frame_bad && !in_startup && !in_restart
                           && irq_mask[MASK_FAIL_POS];
         irq_flags_read <= frame_ok && (frame.addr == ADDR_IRQ)
                           && frame.readback_choice;
         ctrl_update    <= wr_ctrl && !cw_bad;
      end
   end

   // Control word: period and mode together
   always_ff @(posedge clk) begin
      if (!reset_n)
         operation_control_word <= ssr_ctrl_word_t'(WORD_ZERO);
      else if (wr_ctrl && !cw_bad)
         operation_control_word <= cw;
   end

   // Once-only options
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         once_only_options <= WORD_ZERO;
         once_closed_q     <= 1'b0;
      end else begin
         if (wr_opts)
            once_only_options <= frame.data;
         if (frame_ok)
            once_closed_q <= 1'b1;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk) begin
      if (!reset_n)
         irq_mask <= WORD_ZERO;
      else if (wr_mask)
         irq_mask <= frame.data;
   end

   // System setup; development bit loaded by options write, clear-only on setup write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         system_setup <= WORD_ZERO;
      end else if (wr_opts) begin
         system_setup[SDM_POS] <= frame.data[OPT_SDM_POS];
      end else if (wr_setup) begin
         system_setup          <= frame.data;
         system_setup[SDM_POS] <= system_setup[SDM_POS] && frame.data[SDM_POS];
      end
   end

   // Transceiver control
   always_ff @(posedge clk) begin
      if (!reset_n)
         transceiver_control <= WORD_ZERO;
      else if (wr_xcvr)
         transceiver_control <= frame.data;
   end

   // Scratch words; identity flag only cleared
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scratch_word_zero <= {1'b1, ID_CODE};
         scratch_word_one  <= WORD_ZERO;
      end else begin
         if (wr_scr0) begin
            scratch_word_zero[ID_FLAG_POS-1:0] <= frame.data[ID_FLAG_POS-1:0];
            scratch_word_zero[ID_FLAG_POS]     <= scratch_word_zero[ID_FLAG_POS]
                                                  && frame.data[ID_FLAG_POS];
         end
         if (wr_scr1)
            scratch_word_one <= frame.data;
      end
   end

   // Feedback selection
   logic [11:0] feedback;

   always_comb begin
      case ({rx_q[1:0], sdi_s_q})
         {ADDR_CONTROL, 1'b0}: feedback = system_condition_readback;
         {ADDR_CONTROL, 1'b1}: feedback = fault_report_readback;
         {ADDR_IRQ, 1'b0}:     feedback = irq_mask;
         {ADDR_IRQ, 1'b1}:     feedback = irq_flags;
         {ADDR_SETUP, 1'b0}:   feedback = system_setup;
         {ADDR_SETUP, 1'b1}:   feedback = scratch_word_zero;
         {ADDR_XCVR, 1'b0}:    feedback = transceiver_control;
         {ADDR_XCVR, 1'b1}:    feedback = scratch_word_one;
         default:              feedback = WORD_ZERO;
      endcase
   end

   // Transmit shifter
   logic [15:0] tx_q;
   logic        hdr_load;

   assign hdr_load = sck_fall && (cnt_q == HDR_READY_CNT - CNT_ONE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_q       <= FRAME_ZERO;
         serial_out <= 1'b0;
      end else if (frame_start) begin
         tx_q       <= FRAME_ZERO;
         serial_out <= 1'b0;
      end else if (sck_rise) begin
         tx_q       <= {tx_q[14:0], 1'b0};
         serial_out <= tx_q[15];
      end else if (hdr_load) begin
         tx_q[FB_HI:FB_LO] <= feedback;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         serial_out_en <= 1'b0;
      else
         serial_out_en <= !sel_s_q;
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [11:0] fb_hold_q;
   always_ff @(posedge clk) begin
      if (!reset_n)
         fb_hold_q <= WORD_ZERO;
      else if (hdr_load)
         fb_hold_q <= feedback;
   end

   a_out_float_idle: assert property (sel_s_q |=> !serial_out_en)
      else $error("serial output driven while deselected");
   a_reset_blocks_frame: assert property (frame_end && !rst_s_q
      |=> !ctrl_update && !reset_request && !spi_fail_irq)
      else $error("frame acted on during system reset");
   a_count_fail_reset: assert property (frame_bad && in_startup
      |=> reset_request && !spi_fail_irq && !ctrl_update)
      else $error("clock count failure in start-up did not reset");
   a_count_fail_irq: assert property (frame_bad && in_run && irq_mask[MASK_FAIL_POS]
      |=> spi_fail_irq && !reset_request && $stable(irq_mask))
      else $error("clock count failure did not interrupt");
   a_restart_mode_chk: assert property (wr_ctrl && in_restart
      && cw.operating_select != OM_INIT_NORMAL |=> reset_request && !ctrl_update)
      else $error("restart accepted a wrong mode");
   a_flash_chk: assert property (wr_ctrl && cw.operating_select == OM_INIT_FLASH
      && !(in_startup && flash_seq_seen) |=> reset_request)
      else $error("init flash accepted illegally");
   a_wdd_chk: assert property (wr_ctrl && cw.watchdog_off_bit
      |=> reset_request && $stable(operation_control_word))
      else $error("watchdog off bit accepted");
   a_period_chk: assert property (wr_ctrl && !period_ok |=> reset_request)
      else $error("illegal watch period accepted");
   a_run_mode_chk: assert property (wr_ctrl && in_run && !om_run_ok
      |=> reset_request && !spi_fail_irq)
      else $error("illegal mode in run accepted");
   a_ctrl_together: assert property (ctrl_update
      |-> operation_control_word == ssr_ctrl_word_t'($past(frame.data)))
      else $error("control word not updated whole");
   a_read_only_keep: assert property (frame_ok && frame.no_write_flag
      |=> $stable(irq_mask) && $stable(system_setup) && !ctrl_update
      && $stable(scratch_word_one))
      else $error("read-only frame changed a register");
   a_feedback_out: assert property (hdr_load
      |=> tx_q[FB_HI:FB_LO] == fb_hold_q)
      else $error("feedback word not loaded");
   a_once_only: assert property (once_closed_q |=> $stable(once_only_options))
      else $error("once-only options rewritten");
   a_sdm_no_set: assert property (!wr_opts ##1 $rose(system_setup[SDM_POS]) |-> 0)
      else $error("development bit set by setup write");
   a_scratch_locked: assert property (in_run |=> $stable(scratch_word_zero)
      && $stable(scratch_word_one))
      else $error("scratch word changed outside programming");

   c_good_write: cover property (ctrl_update);
   c_bad_count: cover property (frame_bad);
   c_flag_read: cover property (irq_flags_read);
   c_scratch_write: cover property (wr_scr0);

endmodule

// ### ssr_spi_master.sv
`timescale 1ns/1ps
module ssr_spi_master (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      frame_select_n,
   output logic      serial_clk,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_en
);
   localparam int HALF = 8;
   logic idle_q;

   initial begin
      frame_select_n = 1'b1;
      serial_clk     = 1'b0;
      serial_in      = 1'b0;
      idle_q         = 1'b1;
   end

   // Idle data line toggles so no stale bit is seen
   always @(posedge clk) begin
      if (idle_q) begin
         serial_in <= ~serial_in;
      end
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Frame of n clock periods, MSB first, answer collected on falls
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      @(posedge clk);
      idle_q <= 1'b0;
      @(posedge clk);
      frame_select_n <= 1'b0;
      serial_in      <= tx[15];
      wait_clk(HALF);
      for (i = 0; i < n; i++) begin
         serial_clk <= 1'b1;
         if (i > 0) begin
            serial_in <= (i < 16) ? tx[15 - i] : 1'b0;
         end
         wait_clk(HALF);
         serial_clk <= 1'b0;
         rx = {rx[14:0], serial_out_en ? serial_out : 1'bx};
         wait_clk(HALF);
      end
      frame_select_n <= 1'b1;
      idle_q         <= 1'b1;
      wait_clk(HALF);
   endtask
endmodule

// ### test_ssr_spi_regs.sv
`timescale 1ns/1ps
module test_ssr_spi_regs;
   import ssr_pkg::*;
   localparam logic [10:0] ID_VAL = 11'h35A; // Arbitrary identity value
   logic           clk            = 1'b0;
   logic           reset_n        = 1'b0;
   logic           system_reset_n = 1'b1;
   logic           power_on_start = 1'b1;
   logic           flash_seq_seen = 1'b0;
   ssr_mode_t      cur_mode       = MD_STARTUP;
   logic [11:0]    system_condition_readback = 12'h000;
   logic [11:0]    fault_report_readback     = 12'h000;
   logic [11:0]    irq_flags                 = 12'h000;
   logic           frame_select_n, serial_clk, serial_in, serial_out, serial_out_en;
   ssr_ctrl_word_t operation_control_word;
   logic           ctrl_update, reset_request, spi_fail_irq, irq_flags_read;
   logic [11:0]    irq_mask, once_only_options, system_setup, transceiver_control;
   logic [11:0]    scratch_word_zero, scratch_word_one;
   int             fails = 0;
   int             tests_run = 0;
   int             n_upd = 0, n_rst = 0, n_irq = 0, n_rd = 0;
   int             d_upd, d_rst, d_irq, d_rd;
   integer         seed = 32'h5f1b_1ffd;
   logic [15:0]    rx;
   logic [11:0]    d1, s0, s1, x, y, m;
   logic [11:0]    prev, dat;
   logic [5:0]     wpl [10] = '{WP_C0, WP_C1, WP_C2, WP_C3, WP_C4,
                                WP_C5, WP_C6, WP_C7, WP_C8, WP_C9};
   ssr_mode_t      cm [9] = '{MD_STARTUP, MD_STARTUP, MD_RESTART, MD_STARTUP, MD_NORMAL,
                              MD_STARTUP, MD_STARTUP, MD_NORMAL, MD_STANDBY};
   logic [2:0]     om [9] = '{OM_INIT_NORMAL, OM_NORMAL, OM_STANDBY, OM_INIT_FLASH,
                              OM_INIT_FLASH, OM_INIT_NORMAL, OM_INIT_NORMAL, OM_SLEEP,
                              OM_INIT_NORMAL};
   logic [8:0]     wdd_v = 9'h020;
   logic [8:0]     wpb_v = 9'h040;
   logic [8:0]     bad_v = 9'h17E;

   always #2.5 clk = ~clk;

   ssr_spi_regs #(.ID_CODE(ID_VAL)) i_dut (.*);

   ssr_spi_master i_master (.clk, .frame_select_n, .serial_clk, .serial_in,
                            .serial_out, .serial_out_en);

   // Pulse counters
   always @(posedge clk) begin
      if (ctrl_update === 1'b1) n_upd <= n_upd + 1;
      if (reset_request === 1'b1) n_rst <= n_rst + 1;
      if (spi_fail_irq === 1'b1) n_irq <= n_irq + 1;
      if (irq_flags_read === 1'b1) n_rd <= n_rd + 1;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic setm(input ssr_mode_t md, input logic pon);
      @(posedge clk);
      cur_mode       <= md;
      power_on_start <= pon;
   endtask

   // One frame with fresh readback words, then pulse counts
   task automatic run(input logic [15:0] tx, input int n);
      int b_upd, b_rst, b_irq, b_rd;
      @(posedge clk);
      system_condition_readback <= 12'($random(seed));
      fault_report_readback     <= 12'($random(seed));
      irq_flags                 <= 12'($random(seed));
      b_upd = n_upd;
      b_rst = n_rst;
      b_irq = n_irq;
      b_rd  = n_rd;
      i_master.xfer(tx, n, rx);
      repeat (8) @(posedge clk);
      d_upd = n_upd - b_upd;
      d_rst = n_rst - b_rst;
      d_irq = n_irq - b_irq;
      d_rd  = n_rd - b_rd;
      chk("serial_out_en", 16'h0000, {15'h0000, serial_out_en});
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200_000;
      fails++;
      end_of_test();
   end

   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("scratch0", {4'h0, 1'b1, ID_VAL}, {4'h0, scratch_word_zero});
      chk("scratch1", 16'h0000, {4'h0, scratch_word_one});
      chk("ctrl", 16'h0000, {4'h0, operation_control_word});
      d1 = 12'($random(seed)) | 12'h001;
      run({ADDR_IRQ, 2'b00, d1}, 16);
      chk("options", {4'h0, d1}, {4'h0, once_only_options});
      run({ADDR_IRQ, 2'b00, ~d1}, 16);
      chk("options again", {4'h0, d1}, {4'h0, once_only_options});
      for (int i = 0; i < 4; i++) begin
         setm(i[1] ? MD_NORMAL : MD_STARTUP, 1'b0);
         run({ADDR_CONTROL, i[0], 1'b1, 12'($random(seed))}, 16);
         dat = i[0] ? fault_report_readback : system_condition_readback;
         chk("read addr0", {4'h0, dat}, rx);
         chk("no write", 16'h0000, 16'(d_upd + d_rst));
      end
      for (int i = 0; i < 9; i++) begin
         setm(cm[i], 1'b0);
         prev = operation_control_word;
         dat  = {wpb_v[i] ? 6'h00 : wpl[$unsigned($random(seed)) % 10], om[i], wdd_v[i], 2'b00};
         run({ADDR_CONTROL, 2'b00, dat}, 16);
         chk("reset req", {15'h0000, bad_v[i]}, 16'(d_rst));
         chk("ctrl upd", {15'h0000, !bad_v[i]}, 16'(d_upd + d_irq));
         chk("ctrl", {4'h0, bad_v[i] ? prev : dat}, {4'h0, operation_control_word});
      end
      flash_seq_seen <= 1'b1;
      setm(MD_STARTUP, 1'b0);
      dat = {WP_C3, OM_INIT_FLASH, 1'b0, 2'b00};
      run({ADDR_CONTROL, 2'b00, dat}, 16);
      chk("flash reset req", 16'h0000, 16'(d_rst));
      chk("flash ctrl", {4'h0, dat}, {4'h0, operation_control_word});
      s0 = 12'($random(seed));
      s1 = 12'($random(seed));
      run({ADDR_SETUP, 2'b00, s0}, 16);
      setm(MD_FLASH, 1'b0);
      run({ADDR_XCVR, 2'b00, s1}, 16);
      chk("scratch0", {4'h0, s0}, {4'h0, scratch_word_zero});
      chk("scratch1", {4'h0, s1}, {4'h0, scratch_word_one});
      setm(MD_NORMAL, 1'b0);
      x = 12'($random(seed)) & 12'hFFE;
      run({ADDR_SETUP, 2'b10, x}, 16);
      chk("scratch0 echo", {4'h0, s0}, rx);
      chk("setup", {4'h0, x}, {4'h0, system_setup});
      chk("scratch0 kept", {4'h0, s0}, {4'h0, scratch_word_zero});
      y = 12'($random(seed));
      run({ADDR_XCVR, 2'b10, y}, 16);
      chk("scratch1 echo", {4'h0, s1}, rx);
      chk("xcvr", {4'h0, y}, {4'h0, transceiver_control});
      m = 12'($random(seed)) | 12'h001;
      run({ADDR_IRQ, 2'b00, m}, 16);
      chk("mask", {4'h0, m}, {4'h0, irq_mask});
      run({ADDR_IRQ, 2'b11, 12'h000}, 16);
      chk("flags", {4'h0, irq_flags}, rx);
      chk("flags read", 16'h0001, 16'(d_rd));
      run({ADDR_IRQ, 2'b01, 12'h000}, 16);
      chk("mask echo", {4'h0, m}, rx);
      for (int i = 0; i < 3; i++) begin
         setm(i == 2 ? MD_STARTUP : MD_NORMAL, 1'b0);
         run({ADDR_IRQ, 2'b00, ~m}, i == 1 ? 17 : 15);
         chk("count irq", {15'h0000, i != 2}, 16'(d_irq));
         chk("count rst", {15'h0000, i == 2}, 16'(d_rst));
         chk("count mask", {4'h0, m}, {4'h0, irq_mask});
      end
      setm(MD_NORMAL, 1'b0);
      @(posedge clk);
      system_reset_n <= 1'b0;
      run({ADDR_XCVR, 2'b00, ~y}, 16);
      chk("held xcvr", {4'h0, y}, {4'h0, transceiver_control});
      @(posedge clk);
      system_reset_n <= 1'b1;
      run({ADDR_XCVR, 2'b00, ~y}, 16);
      chk("xcvr", {4'h0, ~y}, {4'h0, transceiver_control});
      end_of_test();
   end
endmodule
